/* design/tncf_pkg.sv */
// Constants shared by the host command interpreter of the token network node.
// Assumes a single 200 MHz clock domain and an 8-bit register port.
//
// Summary of operation
// - Rate command with argument 0x09 selects 10 Mbit/s signalling.
// - Own-node command stores its byte as our network identifier.
// - Join command, no argument, starts network participation.
// - Destination command stores target node for selected page; code keeps one node for the next transmit-armed page.
// - Length low and high byte commands combine into 16-bit length.
// - NAK limit 0x17 aborts a transmission after 128 NAKs.
// - Transmit-arm command marks the argument page ready and starts sending.
// - Receive-arm command prepares the argument page for next packet.
// - Page query reports whether that page transmitted successfully.
// - Page query on receive page reports successful reception.
// - Data port reads or writes payload bytes in order.
// - Page select sets pointer past the four header bytes.
// - Page header holds length, source and destination identifiers.
// - Pointer rewinds to 0 via low byte after select, or both bytes.
package tncf_pkg;

  localparam int TNCF_ADDR_W = 4;

  // Register indices (byte address is four times the index)
  localparam logic [3:0] TNCF_REG_ARG     = 4'h0;
  localparam logic [3:0] TNCF_REG_CMD     = 4'h1;
  localparam logic [3:0] TNCF_REG_DATA    = 4'h2;
  localparam logic [3:0] TNCF_REG_PTR_L   = 4'h3;
  localparam logic [3:0] TNCF_REG_PTR_H   = 4'h4;
  localparam logic [3:0] TNCF_REG_RESULT  = 4'h5;
  localparam logic [3:0] TNCF_REG_STATUS  = 4'h6;
  localparam logic [3:0] TNCF_REG_IRQ_STS = 4'h7;
  localparam logic [3:0] TNCF_REG_IRQ_CLR = 4'h8;
  localparam logic [3:0] TNCF_REG_IRQ_EN  = 4'h9;
  localparam logic [3:0] TNCF_REG_RATE    = 4'hA;
  localparam logic [3:0] TNCF_REG_NODE    = 4'hB;

  // Command codes
  typedef enum logic [7:0] {
    TNCF_SET_SIGNALLING_RATE_CMD     = 8'h01,
    TNCF_SET_OWN_NODE_ID_CMD         = 8'h02,
    TNCF_JOIN_NETWORK_CMD            = 8'h03,
    TNCF_SELECT_PAGE_CMD             = 8'h04,
    TNCF_SET_DESTINATION_NODE_CMD    = 8'h05,
    TNCF_SET_TRANSMIT_SOURCE_NODE_CMD = 8'h06,
    TNCF_SET_LENGTH_LOW_BYTE_CMD     = 8'h07,
    TNCF_SET_LENGTH_HIGH_BYTE_CMD    = 8'h08,
    TNCF_SET_EXCESS_NAK_LIMIT_CMD    = 8'h09,
    TNCF_ARM_PAGE_TRANSMIT_CMD       = 8'h0A,
    TNCF_ARM_PAGE_RECEIVE_CMD        = 8'h0B,
    TNCF_QUERY_PAGE_RESULT_CMD       = 8'h0C
  } tncf_cmd_t;

  localparam logic [7:0]  TNCF_RATE_10M_ARG   = 8'h09;
  localparam logic [7:0]  TNCF_NAK_128_ARG    = 8'h17;
  localparam logic [15:0] TNCF_NAK_128_COUNT  = 16'h0080;
  localparam logic [15:0] TNCF_NAK_INF_COUNT  = 16'hFFFF;
  localparam logic [7:0]  TNCF_HEADER_BYTES   = 8'h04;
  // Header layout inside a page
  localparam logic [7:0]  TNCF_HDR_SRC        = 8'h00;
  localparam logic [7:0]  TNCF_HDR_DST        = 8'h01;
  localparam logic [7:0]  TNCF_HDR_LEN_L      = 8'h02;
  localparam logic [7:0]  TNCF_HDR_LEN_H      = 8'h03;
  // Page result codes
  localparam logic [7:0]  TNCF_RES_IDLE       = 8'h00;
  localparam logic [7:0]  TNCF_RES_TX_ARMED   = 8'h01;
  localparam logic [7:0]  TNCF_RES_TX_OK      = 8'h02;
  localparam logic [7:0]  TNCF_RES_TX_ABORT   = 8'h03;
  localparam logic [7:0]  TNCF_RES_RX_ARMED   = 8'h04;
  localparam logic [7:0]  TNCF_RES_RX_OK      = 8'h05;
  // Interrupt bits
  localparam int TNCF_IRQ_TX_DONE  = 0;
  localparam int TNCF_IRQ_TX_ABORT = 1;
  localparam int TNCF_IRQ_RX_DONE  = 2;
  localparam int TNCF_IRQ_CMD_DONE = 3;
  // Busy countdown start; a command occupies the interpreter one cycle longer
  localparam logic [3:0]  TNCF_CMD_CYCLES     = 4'h4;
  localparam logic [7:0]  TNCF_RATE_RESET     = 8'h00;
  localparam logic [7:0]  TNCF_NODE_RESET     = 8'h00;

endpackage

/* design/tncf_page_ram.sv */
// Flip-flop page memory: one write port and one combined read port.
// Assumes writes and reads are single-cycle, synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module tncf_page_ram
  import tncf_pkg::*;
#(
  parameter int PAGES  = 4,
  parameter int PAGE_W = 64
)
(
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic                        wr_en,
  input  wire logic [$clog2(PAGES)-1:0]    wr_page,
  input  wire logic [$clog2(PAGE_W)-1:0]   wr_addr,
  input  wire logic [7:0]                  wr_data,
  input  wire logic [$clog2(PAGES)-1:0]    rd_page,
  input  wire logic [$clog2(PAGE_W)-1:0]   rd_addr,
  output logic      [7:0]                  rd_data
);

  logic [7:0] mem [PAGES*PAGE_W];
  logic [7:0] next_rd_data;

  always_comb
  begin
    next_rd_data = mem[{rd_page, rd_addr}];
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < PAGES*PAGE_W; i++)
        mem[i] <= 8'h00;
      rd_data <= 8'h00;
    end
    else
    begin
      if (wr_en)
        mem[{wr_page, wr_addr}] <= wr_data;
      rd_data <= next_rd_data;
    end
  end

endmodule
`default_nettype wire

/* design/tncf_host_cmd.sv */
// Host command interpreter: argument and command registers, page pointer,
// data port, per-page results and interrupt logic.
// Assumes the register master follows the one-cycle strobe protocol and the
// network engine reports transmit, NAK and receive events as pulses.
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module tncf_host_cmd
  import tncf_pkg::*;
#(
  parameter int PAGES  = 4,
  parameter int PAGE_W = 64
)
(
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic [TNCF_ADDR_W-1:0]    reg_addr,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [7:0]                reg_rdata,
  output logic                           irq,
  output logic                           cmd_busy,
  output logic                           rate_10m,
  output logic      [7:0]                own_node_id,
  output logic                           net_joined,
  output logic                           tx_start,
  output logic      [$clog2(PAGES)-1:0]  tx_page,
  output logic      [15:0]               tx_length,
  output logic      [7:0]                tx_source_node,
  output logic                           tx_abort,
  input  wire logic                      tx_ack,
  input  wire logic                      tx_nak,
  output logic                           rx_armed,
  output logic      [$clog2(PAGES)-1:0]  rx_page,
  input  wire logic                      rx_done,
  input  wire logic                      rx_wr,
  input  wire logic [$clog2(PAGE_W)-1:0] rx_addr,
  input  wire logic [7:0]                rx_data
);

  localparam int PW = $clog2(PAGES);
  localparam int AW = $clog2(PAGE_W);

  typedef enum logic [1:0] {
    TNCF_IDLE = 2'b00,
    TNCF_EXEC = 2'b01,
    TNCF_HDR  = 2'b10
  } tncf_state_t;

  function automatic logic [PW-1:0] tncf_page_of(input logic [7:0] v);
    tncf_page_of = v[PW-1:0];
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // State
  tncf_state_t      state, next_state;
  logic [3:0]       busy_cnt, next_busy_cnt;
  logic [7:0]       arg, next_arg;
  logic [7:0]       cmd, next_cmd;
  logic [7:0]       hdr_step, next_hdr_step;
  logic [PW-1:0]    sel_page, next_sel_page;
  logic [15:0]      ptr, next_ptr;
  logic             just_sel, next_just_sel;
  logic [7:0]       dest_node, next_dest_node;
  logic [7:0]       next_own_node_id;
  logic [7:0]       rate_code, next_rate_code;
  logic             next_net_joined;
  logic [15:0]      next_tx_length;
  logic [7:0]       next_tx_source_node;
  logic [15:0]      nak_limit, next_nak_limit;
  logic [15:0]      nak_cnt, next_nak_cnt;
  logic             tx_active, next_tx_active;
  logic             next_tx_start;
  logic             next_tx_abort;
  logic [PW-1:0]    next_tx_page;
  logic             next_rx_armed;
  logic [PW-1:0]    next_rx_page;
  logic [7:0]       result [PAGES];
  logic [7:0]       next_result [PAGES];
  logic [7:0]       query_res, next_query_res;
  logic [3:0]       irq_sts, next_irq_sts;
  logic [3:0]       irq_en, next_irq_en;
  logic [7:0]       next_reg_rdata;
  logic [7:0]       rdata_q;
  logic             rd_data_pend, next_rd_data_pend;

  // Memory port wiring
  logic             mem_wr;
  logic [PW-1:0]    mem_wr_page;
  logic [AW-1:0]    mem_wr_addr;
  logic [7:0]       mem_wr_data;
  logic [7:0]       mem_rd_data;
  logic             host_data_wr;
  logic [3:0]       ev;

  assign cmd_busy = (state != TNCF_IDLE);
  assign rate_10m = (rate_code == TNCF_RATE_10M_ARG);
  assign irq      = |(irq_sts & irq_en);
  // Data port reads take the registered memory output, which holds the
  // byte at the pointer as it stood at the strobe edge
  assign reg_rdata = rd_data_pend ? mem_rd_data : rdata_q;

  tncf_page_ram #(
    .PAGES  (PAGES),
    .PAGE_W (PAGE_W)
  ) u_ram (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (mem_wr),
    .wr_page (mem_wr_page),
    .wr_addr (mem_wr_addr),
    .wr_data (mem_wr_data),
    .rd_page (sel_page),
    .rd_addr (ptr[AW-1:0]),
    .rd_data (mem_rd_data)
  );

  //////////////////////////////////////////////////////////////////////////
  // Memory write arbitration: header fill, receive path, host data port
  assign host_data_wr = reg_wr && (reg_addr == TNCF_REG_DATA);

  always_comb
  begin
    mem_wr      = 1'b0;
    mem_wr_page = sel_page;
    mem_wr_addr = ptr[AW-1:0];
    mem_wr_data = reg_wdata;
    if (state == TNCF_HDR)
    begin
      // Header is built after transmit arming, before the engine starts
      mem_wr      = 1'b1;
      mem_wr_page = tx_page;
      mem_wr_addr = hdr_step[AW-1:0];
      case (hdr_step)
        // Own id stands in for an unset bridge source
        TNCF_HDR_SRC:   mem_wr_data = (tx_source_node == 8'h00) ?
                                      own_node_id : tx_source_node;
        TNCF_HDR_DST:   mem_wr_data = dest_node;
        TNCF_HDR_LEN_L: mem_wr_data = tx_length[7:0];
        default:        mem_wr_data = tx_length[15:8];
      endcase
    end
    else if (rx_wr)
    begin
      mem_wr      = 1'b1;
      mem_wr_page = rx_page;
      mem_wr_addr = rx_addr;
      mem_wr_data = rx_data;
    end
    else if (host_data_wr)
    begin
      mem_wr = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Command interpreter and registers
  always_comb
  begin
    next_state          = state;
    next_busy_cnt       = busy_cnt;
    next_arg            = arg;
    next_cmd            = cmd;
    next_hdr_step       = hdr_step;
    next_sel_page       = sel_page;
    next_ptr            = ptr;
    next_just_sel       = just_sel;
    next_dest_node      = dest_node;
    next_own_node_id    = own_node_id;
    next_rate_code      = rate_code;
    next_net_joined     = net_joined;
    next_tx_length      = tx_length;
    next_tx_source_node = tx_source_node;
    next_nak_limit      = nak_limit;
    next_nak_cnt        = nak_cnt;
    next_tx_active      = tx_active;
    next_tx_start       = 1'b0;
    next_tx_abort       = 1'b0;
    next_tx_page        = tx_page;
    next_rx_armed       = rx_armed;
    next_rx_page        = rx_page;
    next_result         = result;
    next_query_res      = query_res;
    next_irq_en         = irq_en;
    next_rd_data_pend   = 1'b0;
    ev                  = 4'h0;

    // Register port writes; host must not retarget arg while busy
    if (reg_wr)
    begin
      case (reg_addr)
        TNCF_REG_ARG:
          if (state == TNCF_IDLE)
            next_arg = reg_wdata;
        TNCF_REG_CMD:
          if (state == TNCF_IDLE)
          begin
            next_cmd      = reg_wdata;
            next_state    = TNCF_EXEC;
            next_busy_cnt = TNCF_CMD_CYCLES;
          end
        TNCF_REG_DATA:
        begin
          next_ptr      = ptr + 16'h0001;
          next_just_sel = 1'b0;
        end
        TNCF_REG_PTR_L:
        begin
          // Low byte zero right after selection rewinds fully
          if (just_sel && reg_wdata == 8'h00)
            next_ptr = 16'h0000;
          else
            next_ptr = {ptr[15:8], reg_wdata};
          next_just_sel = 1'b0;
        end
        TNCF_REG_PTR_H:
        begin
          next_ptr      = {reg_wdata, ptr[7:0]};
          next_just_sel = 1'b0;
        end
        TNCF_REG_IRQ_EN:
          next_irq_en = reg_wdata[3:0];
        default:
        begin
        end
      endcase
    end

    if (reg_rd && reg_addr == TNCF_REG_DATA)
    begin
      next_ptr          = ptr + 16'h0001;
      next_just_sel     = 1'b0;
      next_rd_data_pend = 1'b1;
    end

    case (state)
      TNCF_EXEC:
      begin
        if (busy_cnt != 4'h0)
          next_busy_cnt = busy_cnt - 4'h1;
        else
        begin
          next_state = TNCF_IDLE;
          ev[TNCF_IRQ_CMD_DONE] = 1'b1;
          case (cmd)
            TNCF_SET_SIGNALLING_RATE_CMD:
              next_rate_code = arg;
            TNCF_SET_OWN_NODE_ID_CMD:
              next_own_node_id = arg;
            TNCF_JOIN_NETWORK_CMD:
              next_net_joined = 1'b1;
            TNCF_SELECT_PAGE_CMD:
            begin
              next_sel_page = tncf_page_of(arg);
              next_ptr      = {8'h00, TNCF_HEADER_BYTES};
              next_just_sel = 1'b1;
            end
            TNCF_SET_DESTINATION_NODE_CMD:
              next_dest_node = arg;
            TNCF_SET_TRANSMIT_SOURCE_NODE_CMD:
              next_tx_source_node = arg;
            TNCF_SET_LENGTH_LOW_BYTE_CMD:
              next_tx_length = {tx_length[15:8], arg};
            TNCF_SET_LENGTH_HIGH_BYTE_CMD:
              next_tx_length = {arg, tx_length[7:0]};
            TNCF_SET_EXCESS_NAK_LIMIT_CMD:
              if (arg == TNCF_NAK_128_ARG)
                next_nak_limit = TNCF_NAK_128_COUNT;
              else
                next_nak_limit = TNCF_NAK_INF_COUNT;
            TNCF_ARM_PAGE_TRANSMIT_CMD:
            begin
              next_tx_page  = tncf_page_of(arg);
              next_result[tncf_page_of(arg)] = TNCF_RES_TX_ARMED;
              next_state    = TNCF_HDR;
              next_hdr_step = TNCF_HDR_SRC;
            end
            TNCF_ARM_PAGE_RECEIVE_CMD:
            begin
              next_rx_page  = tncf_page_of(arg);
              next_rx_armed = 1'b1;
              next_result[tncf_page_of(arg)] = TNCF_RES_RX_ARMED;
            end
            TNCF_QUERY_PAGE_RESULT_CMD:
              next_query_res = result[tncf_page_of(arg)];
            default:
            begin
            end
          endcase
        end
      end
      TNCF_HDR:
      begin
        if (hdr_step == TNCF_HDR_LEN_H)
        begin
          next_state     = TNCF_IDLE;
          next_tx_start  = 1'b1;
          next_tx_active = 1'b1;
          next_nak_cnt   = 16'h0000;
          // Own id is the source unless bridge mode replaced it
          if (tx_source_node == 8'h00)
            next_tx_source_node = own_node_id;
        end
        else
          next_hdr_step = hdr_step + 8'h01;
      end
      default:
      begin
      end
    endcase

    // Network engine events
    if (tx_active && tx_ack)
    begin
      next_tx_active = 1'b0;
      next_result[tx_page] = TNCF_RES_TX_OK;
      ev[TNCF_IRQ_TX_DONE] = 1'b1;
    end
    else if (tx_active && tx_nak)
    begin
      next_nak_cnt = nak_cnt + 16'h0001;
      if (next_nak_cnt >= nak_limit)
      begin
        next_tx_active = 1'b0;
        next_tx_abort  = 1'b1;
        next_result[tx_page] = TNCF_RES_TX_ABORT;
        ev[TNCF_IRQ_TX_ABORT] = 1'b1;
      end
    end
    if (rx_armed && rx_done)
    begin
      next_rx_armed = 1'b0;
      next_result[rx_page] = TNCF_RES_RX_OK;
      ev[TNCF_IRQ_RX_DONE] = 1'b1;
    end
  end

  // Sticky status: a new event wins over a clear in the same cycle
  always_comb
  begin
    next_irq_sts = irq_sts;
    if (reg_wr && reg_addr == TNCF_REG_IRQ_CLR)
      next_irq_sts = irq_sts & ~reg_wdata[3:0];
    next_irq_sts = next_irq_sts | ev;
  end

  //////////////////////////////////////////////////////////////////////////
  // Read mux; data port value comes from the memory one cycle later
  always_comb
  begin
    next_reg_rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        TNCF_REG_ARG:     next_reg_rdata = arg;
        TNCF_REG_CMD:     next_reg_rdata = cmd;
        TNCF_REG_PTR_L:   next_reg_rdata = ptr[7:0];
        TNCF_REG_PTR_H:   next_reg_rdata = ptr[15:8];
        TNCF_REG_RESULT:  next_reg_rdata = query_res;
        TNCF_REG_STATUS:  next_reg_rdata = {5'h00, tx_active, net_joined,
                                            cmd_busy};
        TNCF_REG_IRQ_STS: next_reg_rdata = {4'h0, irq_sts};
        TNCF_REG_IRQ_EN:  next_reg_rdata = {4'h0, irq_en};
        TNCF_REG_RATE:    next_reg_rdata = rate_code;
        TNCF_REG_NODE:    next_reg_rdata = own_node_id;
        default:          next_reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state          <= TNCF_IDLE;
      busy_cnt       <= 4'h0;
      arg            <= 8'h00;
      cmd            <= 8'h00;
      hdr_step       <= 8'h00;
      sel_page       <= '0;
      ptr            <= 16'h0000;
      just_sel       <= 1'b0;
      dest_node      <= 8'h00;
      own_node_id    <= TNCF_NODE_RESET;
      rate_code      <= TNCF_RATE_RESET;
      net_joined     <= 1'b0;
      tx_length      <= 16'h0000;
      tx_source_node <= 8'h00;
      nak_limit      <= TNCF_NAK_INF_COUNT;
      nak_cnt        <= 16'h0000;
      tx_active      <= 1'b0;
      tx_start       <= 1'b0;
      tx_abort       <= 1'b0;
      tx_page        <= '0;
      rx_armed       <= 1'b0;
      rx_page        <= '0;
      for (int i = 0; i < PAGES; i++)
        result[i] <= TNCF_RES_IDLE;
      query_res      <= 8'h00;
      irq_sts        <= 4'h0;
      irq_en         <= 4'h0;
      rd_data_pend   <= 1'b0;
      rdata_q        <= 8'h00;
    end
    else
    begin
      state          <= next_state;
      busy_cnt       <= next_busy_cnt;
      arg            <= next_arg;
      cmd            <= next_cmd;
      hdr_step       <= next_hdr_step;
      sel_page       <= next_sel_page;
      ptr            <= next_ptr;
      just_sel       <= next_just_sel;
      dest_node      <= next_dest_node;
      own_node_id    <= next_own_node_id;
      rate_code      <= next_rate_code;
      net_joined     <= next_net_joined;
      tx_length      <= next_tx_length;
      tx_source_node <= next_tx_source_node;
      nak_limit      <= next_nak_limit;
      nak_cnt        <= next_nak_cnt;
      tx_active      <= next_tx_active;
      tx_start       <= next_tx_start;
      tx_abort       <= next_tx_abort;
      tx_page        <= next_tx_page;
      rx_armed       <= next_rx_armed;
      rx_page        <= next_rx_page;
      result         <= next_result;
      query_res      <= next_query_res;
      irq_sts        <= next_irq_sts;
      irq_en         <= next_irq_en;
      rd_data_pend   <= next_rd_data_pend;
      rdata_q        <= next_reg_rdata;
    end
  end

endmodule
`default_nettype wire

/* bench/tncf_host_cmd_sva.sv */
// Port checker for the host command interpreter.
// Assumes one clock domain; bound onto every tncf_host_cmd instance.
`timescale 1ns/1ps
`default_nettype none
module tncf_host_cmd_sva
  import tncf_pkg::*;
#(
  parameter int PAGES = 4
)
(
  input wire logic                     clk,
  input wire logic                     sys_rst,
  input wire logic [TNCF_ADDR_W-1:0]   reg_addr,
  input wire logic                     reg_wr,
  input wire logic                     cmd_busy,
  input wire logic                     rate_10m,
  input wire logic [7:0]               own_node_id,
  input wire logic                     net_joined,
  input wire logic                     tx_start,
  input wire logic [$clog2(PAGES)-1:0] tx_page,
  input wire logic [15:0]              tx_length,
  input wire logic                     tx_abort
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_take;
    reg_wr && reg_addr == TNCF_REG_CMD && !cmd_busy |=> cmd_busy;
  endproperty
  a_take: assert property (p_take) else $error("command not taken");
  // Arm transmit includes header cycles, hence the wide bound
  property p_done;
    $rose(cmd_busy) |-> ##[1:20] !cmd_busy;
  endproperty
  a_done: assert property (p_done) else $error("command hangs");
  property p_rate;
    $changed(rate_10m) |-> $past(cmd_busy);
  endproperty
  a_rate: assert property (p_rate) else $error("rate moved alone");
  property p_node;
    $changed(own_node_id) |-> $past(cmd_busy);
  endproperty
  a_node: assert property (p_node) else $error("node id moved alone");
  property p_join;
    net_joined |=> net_joined;
  endproperty
  a_join: assert property (p_join) else $error("join lost");
  property p_start;
    tx_start |=> !tx_start && $stable(tx_length) && $stable(tx_page);
  endproperty
  a_start: assert property (p_start) else $error("start unstable");
  property p_abort;
    tx_abort |=> !tx_abort;
  endproperty
  a_abort: assert property (p_abort) else $error("abort too long");
  property p_jrise;
    $rose(net_joined) |-> $past(cmd_busy);
  endproperty
  a_jrise: assert property (p_jrise) else $error("join uncommanded");
endmodule

bind tncf_host_cmd tncf_host_cmd_sva #(.PAGES(PAGES)) u_sva (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .cmd_busy(cmd_busy), .rate_10m(rate_10m), .own_node_id(own_node_id),
  .net_joined(net_joined), .tx_start(tx_start), .tx_page(tx_page),
  .tx_length(tx_length), .tx_abort(tx_abort));
`default_nettype wire

/* bench/tncf_host_cmd_tb.sv */
// Self-checking bench for the host command interpreter.
// Assumes the DUT defaults PAGES=4 and PAGE_W=64.
`timescale 1ns/1ps
`default_nettype none
module tncf_host_cmd_tb import tncf_pkg::*;;
  logic        clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        tx_ack = 1'b0, tx_nak = 1'b0, rx_done = 1'b0, rx_wr = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00, rx_data = 8'h00;
  logic [5:0]  rx_addr = 6'h00;
  logic [7:0]  reg_rdata, own_node_id, tx_source_node;
  logic        irq, cmd_busy, rate_10m, net_joined, tx_start, tx_abort;
  logic        rx_armed, rd_seen = 1'b0;
  logic [1:0]  tx_page, rx_page;
  logic [15:0] tx_length, len;
  logic [7:0]  exp_q[$];
  logic [7:0]  rx_byte[4];
  int          n_fail = 0, compares = 0, n_start = 0, n_abort = 0, i;

  always #2.5 clk = ~clk;

  tncf_host_cmd DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .cmd_busy(cmd_busy),
    .rate_10m(rate_10m), .own_node_id(own_node_id),
    .net_joined(net_joined), .tx_start(tx_start), .tx_page(tx_page),
    .tx_length(tx_length), .tx_source_node(tx_source_node),
    .tx_abort(tx_abort), .tx_ack(tx_ack), .tx_nak(tx_nak),
    .rx_armed(rx_armed), .rx_page(rx_page), .rx_done(rx_done),
    .rx_wr(rx_wr), .rx_addr(rx_addr), .rx_data(rx_data));

  ////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task close_out;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a; reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  task automatic wait_cnt(ref int c, input int v);
    int k;
    for (k = 0; k < 60 && c != v; k++) @(posedge clk);
    if (c != v)
    begin
      n_fail++;
      close_out;
    end
  endtask

  // Argument and command go as one pair, then the bench waits for idle
  task cmd(input logic [7:0] c, input logic [7:0] a);
    int k;
    wr(TNCF_REG_ARG, a);
    wr(TNCF_REG_CMD, c);
    @(posedge clk);
    for (k = 0; k < 60 && cmd_busy !== 1'b0; k++) @(posedge clk);
    if (k == 60)
    begin
      n_fail++;
      close_out;
    end
  endtask

  task pulse(input int k);
    @(posedge clk);
    case (k)
      0: tx_nak <= 1'b1;
      1: tx_ack <= 1'b1;
      default: rx_done <= 1'b1;
    endcase
    @(posedge clk);
    {tx_nak, tx_ack, rx_done} <= 3'b000;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Read data stand only in the cycle after the strobe
  always @(posedge clk)
  begin
    if (rd_seen) chk("reg_rdata", reg_rdata, exp_q.pop_front());
    rd_seen <= reg_rd;
    if (tx_start === 1'b1) n_start <= n_start + 1;
    if (tx_abort === 1'b1) n_abort <= n_abort + 1;
  end

  initial
  begin
    void'($urandom(32'hDAF5));
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk("reset", {rate_10m, net_joined, rx_armed, own_node_id}, 16'h0000);
    wr(TNCF_REG_IRQ_EN, 8'h08);
    cmd(TNCF_SET_SIGNALLING_RATE_CMD, TNCF_RATE_10M_ARG);
    chk("rate_10m", rate_10m, 16'h0001);
    chk("irq", irq, 16'h0001);
    rd(TNCF_REG_IRQ_STS, 8'h08);
    rd(TNCF_REG_RATE, 8'h09);
    wr(TNCF_REG_IRQ_CLR, 8'h08);
    @(posedge clk);
    chk("irq", irq, 16'h0000);
    wr(TNCF_REG_IRQ_EN, 8'h00);
    cmd(TNCF_SET_OWN_NODE_ID_CMD, 8'h63);
    chk("own_node_id", own_node_id, 16'h0063);
    chk("irq", irq, 16'h0000);
    cmd(TNCF_JOIN_NETWORK_CMD, 8'h00);
    chk("net_joined", net_joined, 16'h0001);
    rd(TNCF_REG_STATUS, 8'h02);
    rd(TNCF_REG_NODE, 8'h63);
    rd(4'hF, 8'h00);
    cmd(TNCF_SELECT_PAGE_CMD, 8'h01);
    cmd(TNCF_SET_DESTINATION_NODE_CMD, 8'h80);
    for (i = 0; i < 3; i++) wr(TNCF_REG_DATA, 8'(1 << i));
    len = 16'($urandom);
    cmd(TNCF_SET_LENGTH_LOW_BYTE_CMD, len[7:0]);
    cmd(TNCF_SET_LENGTH_HIGH_BYTE_CMD, len[15:8]);
    cmd(TNCF_SET_EXCESS_NAK_LIMIT_CMD, TNCF_NAK_128_ARG);
    // No transmit source command outside bridge mode
    cmd(TNCF_ARM_PAGE_TRANSMIT_CMD, 8'h01);
    wait_cnt(n_start, 1);
    chk("tx_page", tx_page, 16'h0001);
    chk("tx_length", tx_length, len);
    chk("tx_source_node", tx_source_node, 16'h0063);
    repeat (127) pulse(0);
    repeat (4) @(posedge clk);
    chk("n_abort", 16'(n_abort), 16'h0000);
    pulse(0);
    wait_cnt(n_abort, 1);
    cmd(TNCF_QUERY_PAGE_RESULT_CMD, 8'h01);
    rd(TNCF_REG_RESULT, TNCF_RES_TX_ABORT);
    cmd(TNCF_ARM_PAGE_TRANSMIT_CMD, 8'h01);
    wait_cnt(n_start, 2);
    pulse(1);
    cmd(TNCF_QUERY_PAGE_RESULT_CMD, 8'h01);
    rd(TNCF_REG_RESULT, TNCF_RES_TX_OK);
    cmd(TNCF_ARM_PAGE_RECEIVE_CMD, 8'h02);
    chk("rx_armed", {rx_armed, 6'h00, rx_page}, 16'h0102);
    for (i = 0; i < 4; i++)
    begin
      @(posedge clk);
      rx_byte[i] = 8'($urandom);
      rx_wr <= 1'b1; rx_addr <= 6'(4 + i); rx_data <= rx_byte[i];
    end
    @(posedge clk);
    rx_wr <= 1'b0;
    pulse(2);
    cmd(TNCF_QUERY_PAGE_RESULT_CMD, 8'h02);
    rd(TNCF_REG_RESULT, TNCF_RES_RX_OK);
    cmd(TNCF_SELECT_PAGE_CMD, 8'h02);
    for (i = 0; i < 4; i++) rd(TNCF_REG_DATA, rx_byte[i]);
    rd(TNCF_REG_PTR_L, 8'h08);
    cmd(TNCF_SELECT_PAGE_CMD, 8'h01);
    wr(TNCF_REG_PTR_L, 8'h00);
    rd(TNCF_REG_DATA, 8'h63);
    rd(TNCF_REG_DATA, 8'h80);
    rd(TNCF_REG_DATA, len[7:0]);
    rd(TNCF_REG_DATA, len[15:8]);
    rd(TNCF_REG_DATA, 8'h01);
    rd(TNCF_REG_DATA, 8'h02);
    wr(TNCF_REG_PTR_H, 8'h00);
    wr(TNCF_REG_PTR_L, 8'h00);
    rd(TNCF_REG_DATA, 8'h63);
    repeat (3) @(posedge clk);
    close_out;
  end
endmodule
`default_nettype wire
